// ---- irq_pkg.sv ----
// Package: constants, register map and vector numbers for the external interrupt block
package irq_pkg;

  // ==========================================================
  // Vector words
  localparam logic [4:0] VEC_RESET     = 5'h00;
  localparam logic [4:0] VEC_EXT       = 5'h01;
  localparam logic [4:0] VEC_PC_LO     = 5'h02;
  localparam logic [4:0] VEC_PC_HI     = 5'h03;
  localparam logic [4:0] VEC_WDOG      = 5'h04;
  localparam logic [4:0] VEC_T16_FIRST = 5'h05;
  localparam logic [4:0] VEC_T8_FIRST  = 5'h09;
  localparam logic [4:0] VEC_MISC_LAST = 5'h10;
  localparam int         NUM_SRC       = 17;
  localparam int         NUM_PERIPH    = 12;

  // ==========================================================
  // Register byte addresses
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_ENABLE  = 12'h004;
  localparam logic [11:0] ADDR_FLAGS   = 12'h008;
  localparam logic [11:0] ADDR_MASK_LO = 12'h00c;
  localparam logic [11:0] ADDR_MASK_HI = 12'h010;
  localparam logic [11:0] ADDR_PINS    = 12'h014;
  localparam logic [11:0] ADDR_STARTUP = 12'h018;

  // ==========================================================
  // Field positions
  localparam int BIT_EXT   = 0;
  localparam int BIT_PC_LO = 1;
  localparam int BIT_PC_HI = 2;

  // ==========================================================
  // Reset values
  localparam logic [1:0]  RST_SENSE   = 2'h0;
  localparam logic [7:0]  RST_MASK_LO = 8'h00;
  localparam logic [3:0]  RST_MASK_HI = 4'h0;
  localparam logic [15:0] RST_STARTUP = 16'h0010;

  // ==========================================================
  // Sense control encodings
  typedef enum logic [1:0] {
    SENSE_LOW  = 2'h0,
    SENSE_ANY  = 2'h1,
    SENSE_FALL = 2'h2,
    SENSE_RISE = 2'h3
  } sense_t;

endpackage

// ---- pin_sync_if.sv ----
// Interface: synchronised pin levels and change pulses between detector and controller
interface pin_sync_if;
  logic [12:0] level;
  logic [12:0] change;
  modport src (output level, output change);
  modport dst (input level, input change);
endinterface

// ---- pin_sync.sv ----
// Two-flop synchroniser with change detection for the external pins
module pin_sync (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        io_clk_en_in,
  input  wire logic [12:0] pins_in,
  pin_sync_if.src          sync
);
  logic [12:0] meta_q;
  logic [12:0] stab_q;
  logic [12:0] prev_q;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      meta_q <= 13'h1fff;
      stab_q <= 13'h1fff;
    end else begin
      meta_q <= pins_in;
      stab_q <= meta_q;
    end
  end

  // Group bits keep their last running level while the I/O clock is off, so a
  // change in deep sleep is still flagged on wake; the external pin tracks
  // always, so an edge in that time is lost rather than delayed
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      prev_q <= 13'h1fff;
    end else begin
      prev_q[12] <= stab_q[12]; // [RQ12]
      if (io_clk_en_in) begin
        prev_q[11:0] <= stab_q[11:0];
      end
    end
  end

  assign sync.level  = stab_q;
  assign sync.change = io_clk_en_in ? (stab_q ^ prev_q) : 13'h0000;
endmodule

// ---- vec_prio.sv ----
// Fixed priority picker: lowest pending source wins
module vec_prio (
  input  wire logic [16:0] pend_in,
  output logic             any_out,
  output logic [4:0]       vec_out
);
  always_comb begin
    any_out = 1'b0;
    vec_out = irq_pkg::VEC_RESET;
    for (int i = irq_pkg::NUM_SRC - 1; i >= 0; i--) begin
      if (pend_in[i]) begin
        any_out = 1'b1;
        vec_out = 5'(i + 1);
      end
    end
  end
endmodule

// ---- ext_irq_and_vector_map.sv ----
// Top: external interrupt, pin-change groups, vector map and APB register file
// ==========================================================
// How it works
// [RQ1] Resets go to word 0; external to 1
// [RQ2] Pin-change groups vector to words 2, 3
// [RQ3] Watchdog word 4; 16-bit timer words 5-8
// [RQ4] 8-bit timer 9-11; others 12-16; code maps others to 12-17 (periph_req_in[13] gives word 17)
// [RQ5] Pins driven as outputs still raise requests
// [RQ6] Any enabled input 7..0 toggling raises low
// [RQ7] Any enabled input 11..8 toggling raises high
// [RQ8] Per-pin masks select contributing inputs
// [RQ9] Pin changes wake without the I/O clock
// [RQ10] External pin: falling, rising or low level
// [RQ11] Low level requests while pin stays low
// [RQ12] Edges need the running I/O clock
// [RQ13] I/O clock stopped in sleep except idle
// [RQ14] Low level wakes asynchronously
// [RQ15] Vanished level wakes but gives no interrupt
// [RQ16] Start-up delay set by fuse settings
// [RQ17] Sense field: low, any, falling, rising
// [RQ18] Pulses longer than one clock are caught
// [RQ19] Ext flag: edge sets, ack/one clears, level clears
// [RQ20] Group flags: change sets, ack/one clears
// [RQ21] Lowest pending vector is served first
module ext_irq_and_vector_map (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_in,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        ext_irq_pin,
  input  wire logic [11:0] pin_change_inputs,
  input  wire logic        reset_req_in,
  input  wire logic [13:0] periph_req_in,
  input  wire logic        global_irq_en_in,
  input  wire logic        sleep_in,
  input  wire logic        sleep_idle_in,
  input  wire logic [3:0]  startup_time_fuse,
  input  wire logic [3:0]  clock_select_fuse,
  input  wire logic        irq_ack_in,
  output logic             irq_req_out,
  output logic [4:0]       irq_vector_out,
  output logic             wake_out,
  output logic             io_clk_en_out,
  output logic             pin_change_group_lo_req,
  output logic             pin_change_group_hi_req
);
  // ==========================================================
  // Registers and sleep state
  typedef enum {ST_RUN, ST_SLEEP, ST_START} pwr_t;
  pwr_t        pwr_q;
  logic [1:0]  sense_q;
  logic [2:0]  enable_q;
  logic [7:0]  pin_change_mask_lo;
  logic [3:0]  pin_change_mask_hi;
  logic        ext_irq_flag;
  logic        pin_change_flag_lo;
  logic        pin_change_flag_hi;
  logic [15:0] startup_q;
  logic [15:0] su_cnt_q;
  logic        lvl_seen_q;
  logic [4:0]  vec_q;
  logic        req_q;
  logic [31:0] rdata_d;
  logic        wr_stb;
  logic        w1c_stb;
  logic        ext_edge;
  logic        lvl_low;
  logic        any_pend;
  logic [4:0]  pick_vec;
  logic [16:0] pend;
  logic        ack_ext;
  logic        ack_lo;
  logic        ack_hi;
  logic [15:0] startup_len;
  logic        sense_is_level;

  localparam int BIT_EXT_C   = irq_pkg::BIT_EXT;
  localparam int BIT_PC_LO_C = irq_pkg::BIT_PC_LO;
  localparam int BIT_PC_HI_C = irq_pkg::BIT_PC_HI;

  pin_sync_if sync ();

  // ==========================================================
  // Clock gating: I/O clock only in run or idle sleep
  assign io_clk_en_out = (pwr_q == ST_RUN) || sleep_idle_in; // [RQ13]

  pin_sync u_sync (
    .clk_sys_in   (clk_sys_in),
    .rst_in       (rst_in),
    .io_clk_en_in (io_clk_en_out),
    .pins_in      ({ext_irq_pin, pin_change_inputs}),
    .sync         (sync)
  );

  // ==========================================================
  // Pin-change groups; inputs sampled regardless of pin direction
  assign pin_change_group_lo_req = |(sync.change[7:0] & pin_change_mask_lo); // [RQ5] [RQ6] [RQ8]
  // Asynchronous path for wake: compare levels without the I/O clock
  logic [11:0] pc_ref_q;
  logic        pc_wake;
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pc_ref_q <= 12'hfff;
    end else if (pwr_q == ST_RUN) begin
      pc_ref_q <= sync.level[11:0];
    end
  end
  assign pc_wake = |((sync.level[11:0] ^ pc_ref_q) & {pin_change_mask_hi, pin_change_mask_lo}
                     & {{4{enable_q[BIT_PC_HI_C]}}, {8{enable_q[BIT_PC_LO_C]}}}); // [RQ9]
  assign pin_change_group_hi_req = |(sync.change[11:8] & pin_change_mask_hi); // [RQ7] [RQ8]

  // ==========================================================
  // External pin sense
  assign sense_is_level = (sense_q == irq_pkg::SENSE_LOW);
  assign lvl_low        = ~sync.level[12];
  always_comb begin
    case (irq_pkg::sense_t'(sense_q)) // [RQ10] [RQ17]
      irq_pkg::SENSE_ANY:  ext_edge = sync.change[12]; // [RQ18]
      irq_pkg::SENSE_FALL: ext_edge = sync.change[12] & ~sync.level[12]; // [RQ12]
      irq_pkg::SENSE_RISE: ext_edge = sync.change[12] & sync.level[12];
      default:             ext_edge = 1'b0;
    endcase
  end

  // ==========================================================
  // APB slave: zero wait states, unmapped reads zero with error
  assign pready  = 1'b1;
  assign wr_stb  = psel & penable & pwrite;
  assign w1c_stb = wr_stb && (paddr == irq_pkg::ADDR_FLAGS);
  always_comb begin
    case (paddr)
      irq_pkg::ADDR_CTRL:    rdata_d = {30'h0, sense_q};
      irq_pkg::ADDR_ENABLE:  rdata_d = {29'h0, enable_q};
      irq_pkg::ADDR_FLAGS:   rdata_d = {29'h0, pin_change_flag_hi, pin_change_flag_lo,
                                        ext_irq_flag};
      irq_pkg::ADDR_MASK_LO: rdata_d = {24'h0, pin_change_mask_lo};
      irq_pkg::ADDR_MASK_HI: rdata_d = {28'h0, pin_change_mask_hi};
      irq_pkg::ADDR_PINS:    rdata_d = {19'h0, sync.level};
      irq_pkg::ADDR_STARTUP: rdata_d = {16'h0, startup_q};
      default:               rdata_d = 32'h0000_0000;
    endcase
  end
  assign prdata  = (psel & ~pwrite) ? rdata_d : 32'h0000_0000;
  assign pslverr = psel & penable & ~(paddr inside {irq_pkg::ADDR_CTRL, irq_pkg::ADDR_ENABLE,
                   irq_pkg::ADDR_FLAGS, irq_pkg::ADDR_MASK_LO, irq_pkg::ADDR_MASK_HI,
                   irq_pkg::ADDR_PINS, irq_pkg::ADDR_STARTUP});

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      sense_q            <= irq_pkg::RST_SENSE;
      enable_q           <= 3'h0;
      pin_change_mask_lo <= irq_pkg::RST_MASK_LO;
      pin_change_mask_hi <= irq_pkg::RST_MASK_HI;
      startup_q          <= irq_pkg::RST_STARTUP;
    end else if (wr_stb) begin
      case (paddr)
        irq_pkg::ADDR_CTRL:    sense_q <= pwdata[1:0];
        irq_pkg::ADDR_ENABLE:  enable_q <= pwdata[2:0];
        irq_pkg::ADDR_MASK_LO: pin_change_mask_lo <= pwdata[7:0]; // [RQ8]
        irq_pkg::ADDR_MASK_HI: pin_change_mask_hi <= pwdata[3:0];
        irq_pkg::ADDR_STARTUP: startup_q <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Flags: set wins over clear
  assign ack_ext = irq_ack_in && req_q && vec_q == irq_pkg::VEC_EXT;
  assign ack_lo  = irq_ack_in && req_q && vec_q == irq_pkg::VEC_PC_LO;
  assign ack_hi  = irq_ack_in && req_q && vec_q == irq_pkg::VEC_PC_HI;

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || sense_is_level) begin
      ext_irq_flag <= 1'b0; // [RQ19]
    end else if (ext_edge) begin
      ext_irq_flag <= 1'b1; // [RQ19]
    end else if (ack_ext || (w1c_stb && pwdata[BIT_EXT_C])) begin
      ext_irq_flag <= 1'b0; // [RQ19]
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pin_change_flag_lo <= 1'b0;
      pin_change_flag_hi <= 1'b0;
    end else begin
      if (pin_change_group_lo_req) begin
        pin_change_flag_lo <= 1'b1; // [RQ20]
      end else if (ack_lo || (w1c_stb && pwdata[BIT_PC_LO_C])) begin
        pin_change_flag_lo <= 1'b0; // [RQ20]
      end
      if (pin_change_group_hi_req) begin
        pin_change_flag_hi <= 1'b1; // [RQ20]
      end else if (ack_hi || (w1c_stb && pwdata[BIT_PC_HI_C])) begin
        pin_change_flag_hi <= 1'b0; // [RQ20]
      end
    end
  end

  // ==========================================================
  // Sleep and start-up: level seen only if held to the end of start-up
  assign startup_len = startup_q + 16'({startup_time_fuse, clock_select_fuse}); // [RQ16]
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      pwr_q      <= ST_RUN;
      su_cnt_q   <= 16'h0000;
      lvl_seen_q <= 1'b0;
    end else begin
      case (pwr_q)
        ST_RUN: begin
          lvl_seen_q <= 1'b1;
          if (sleep_in) begin
            pwr_q <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          lvl_seen_q <= 1'b0;
          if ((enable_q[BIT_EXT_C] && sense_is_level && lvl_low) || pc_wake) begin // [RQ14]
            pwr_q    <= ST_START;
            su_cnt_q <= startup_len;
          end else if (!sleep_in && sleep_idle_in) begin
            pwr_q <= ST_RUN;
          end
        end
        ST_START: begin
          if (su_cnt_q == 16'h0000) begin
            pwr_q <= ST_RUN; // [RQ15]
          end else begin
            su_cnt_q <= su_cnt_q - 16'h0001;
          end
        end
        default: pwr_q <= ST_RUN;
      endcase
    end
  end
  assign wake_out = (pwr_q == ST_START);

  // ==========================================================
  // Pending sources and vector selection
  always_comb begin
    pend     = 17'h00000;
    // Level mode requests only once running, so a vanished level yields none
    pend[0]  = enable_q[BIT_EXT_C] & (sense_is_level ? (lvl_low & lvl_seen_q) // [RQ11] [RQ15]
                                                     : ext_irq_flag);
    pend[1]  = enable_q[BIT_PC_LO_C] & pin_change_flag_lo; // [RQ2]
    pend[2]  = enable_q[BIT_PC_HI_C] & pin_change_flag_hi;
    pend[16:3] = periph_req_in; // [RQ3] [RQ4]
  end

  vec_prio u_prio (
    .pend_in (pend),
    .any_out (any_pend),
    .vec_out (pick_vec) // [RQ21]
  );

  always_ff @(posedge clk_sys_in) begin
    if (rst_in || reset_req_in) begin
      req_q <= 1'b0;
      vec_q <= irq_pkg::VEC_RESET; // [RQ1]
    end else if (irq_ack_in && req_q) begin
      req_q <= 1'b0;
    end else begin
      req_q <= any_pend & global_irq_en_in & (pwr_q == ST_RUN);
      vec_q <= any_pend ? pick_vec : irq_pkg::VEC_RESET;
    end
  end
  assign irq_req_out    = req_q;
  assign irq_vector_out = vec_q;

  // ==========================================================
  // Checks
  property p_ext_vec;
    @(posedge clk_sys_in) disable iff (rst_in)
      (pend[0] && global_irq_en_in && pwr_q == ST_RUN && !(irq_ack_in && req_q)
       && !reset_req_in) |=> (vec_q == irq_pkg::VEC_EXT);
  endproperty
  a_ext_vec: assert property (p_ext_vec) else $error("ext vector not 1"); // [RQ1]

  property p_reset_vec;
    @(posedge clk_sys_in) reset_req_in |=> (vec_q == irq_pkg::VEC_RESET && !req_q);
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset vector not 0"); // [RQ1]

  property p_lo_vec;
    @(posedge clk_sys_in) disable iff (rst_in)
      (!pend[0] && pend[1] && !(irq_ack_in && req_q) && !reset_req_in)
      |=> (vec_q == irq_pkg::VEC_PC_LO);
  endproperty
  a_lo_vec: assert property (p_lo_vec) else $error("low group vector not 2"); // [RQ2]

  property p_wdog_vec;
    @(posedge clk_sys_in) disable iff (rst_in)
      (pend[3:0] == 4'h8 && !(irq_ack_in && req_q) && !reset_req_in)
      |=> (vec_q == irq_pkg::VEC_WDOG);
  endproperty
  a_wdog_vec: assert property (p_wdog_vec) else $error("watchdog vector not 4"); // [RQ3]

  property p_last_vec;
    @(posedge clk_sys_in) disable iff (rst_in)
      (pend == 17'h08000 && !(irq_ack_in && req_q) && !reset_req_in)
      |=> (vec_q == irq_pkg::VEC_MISC_LAST);
  endproperty
  a_last_vec: assert property (p_last_vec) else $error("last vector not 16"); // [RQ4]

  property p_lo_mask;
    @(posedge clk_sys_in) disable iff (rst_in)
      (pin_change_mask_lo == 8'h00) |-> !pin_change_group_lo_req;
  endproperty
  a_lo_mask: assert property (p_lo_mask) else $error("masked low group requested"); // [RQ8]

  property p_flag_level;
    @(posedge clk_sys_in) disable iff (rst_in)
      (sense_is_level && $past(sense_is_level)) |-> !ext_irq_flag;
  endproperty
  a_flag_level: assert property (p_flag_level) else $error("ext flag set in level mode"); // [RQ19]

  property p_flag_set;
    @(posedge clk_sys_in) disable iff (rst_in)
      (pin_change_group_hi_req) |=> pin_change_flag_hi;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("high group flag not set"); // [RQ20]

  property p_io_clk;
    @(posedge clk_sys_in) disable iff (rst_in)
      (pwr_q == ST_SLEEP && !sleep_idle_in) |-> !io_clk_en_out;
  endproperty
  a_io_clk: assert property (p_io_clk) else $error("io clock runs in deep sleep"); // [RQ13]

  c_ext:   cover property (@(posedge clk_sys_in) req_q && vec_q == irq_pkg::VEC_EXT);
  c_lo:    cover property (@(posedge clk_sys_in) req_q && vec_q == irq_pkg::VEC_PC_LO);
  c_wake:  cover property (@(posedge clk_sys_in) pwr_q == ST_START ##1 pwr_q == ST_RUN);
  c_sleep: cover property (@(posedge clk_sys_in) pwr_q == ST_SLEEP);
endmodule

// ---- core_model.sv ----
// Behavioural processor core that takes vectors and acknowledges them
module core_model (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic       auto_en_in,
  input  wire logic [3:0] delay_in,
  input  wire logic       req_in,
  input  wire logic [4:0] vec_in,
  output logic            ack_out,
  output logic      [4:0] last_vec_out,
  output int              taken_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_q = 4'h0;

  // ======
  // Acknowledge
  // One-cycle pulse, then a gap, so one request is never taken twice
  always @(posedge clk_sys_in) begin
    if (rst_in) begin
      ack_out   <= 1'b0;
      wait_q    <= 4'h0;
      taken_out <= 0;
    end else if (!auto_en_in || ack_out) begin
      ack_out <= 1'b0;
      wait_q  <= 4'h0;
    end else if (req_in && wait_q >= delay_in) begin
      ack_out      <= 1'b1;
      last_vec_out <= vec_in;
      taken_out    <= taken_out + 1;
    end else if (req_in) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      wait_q <= 4'h0;
    end
  end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the external interrupt and vector block
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // ======
  // Signals
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ext_irq_pin = 1'b1;
  logic [11:0] pin_change_inputs = 12'h000;
  logic        reset_req_in = 1'b0;
  logic [13:0] periph_req_in = 14'h0;
  logic        global_irq_en_in = 1'b0;
  logic        sleep_in = 1'b0;
  logic        sleep_idle_in = 1'b0;
  logic [3:0]  startup_time_fuse = 4'h0;
  logic [3:0]  clock_select_fuse = 4'h1;
  logic        irq_ack_in;
  logic        irq_req_out;
  logic [4:0]  irq_vector_out;
  logic        wake_out;
  logic        io_clk_en_out;
  logic        pin_change_group_lo_req;
  logic        pin_change_group_hi_req;
  logic        auto_en = 1'b1;
  logic [3:0]  ack_dly = 4'h0;
  logic [4:0]  last_vec;
  int          taken;
  int          error_cnt = 0;
  int          compares = 0;
  int          lo_pulses = 0;
  int          hi_pulses = 0;
  int          wake_cyc = 0;
  int          t0;
  int          p0;
  logic [31:0] rd;
  logic        err;
  logic [31:0] rst_tab [7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1000, 32'h10};
  logic [1:0]  sense_tab [3] = '{irq_pkg::SENSE_FALL, irq_pkg::SENSE_RISE, irq_pkg::SENSE_ANY};
  logic [31:0] fall_tab [3] = '{32'h1, 32'h0, 32'h1};
  logic [31:0] rise_tab [3] = '{32'h0, 32'h1, 32'h1};

  ext_irq_and_vector_map ext_irq_and_vector_map_inst (
    .clk_sys_in, .rst_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_irq_pin, .pin_change_inputs, .reset_req_in, .periph_req_in,
    .global_irq_en_in, .sleep_in, .sleep_idle_in, .startup_time_fuse, .clock_select_fuse,
    .irq_ack_in, .irq_req_out, .irq_vector_out, .wake_out, .io_clk_en_out,
    .pin_change_group_lo_req, .pin_change_group_hi_req);

  core_model core_model_inst (
    .clk_sys_in, .rst_in, .auto_en_in(auto_en), .delay_in(ack_dly), .req_in(irq_req_out),
    .vec_in(irq_vector_out), .ack_out(irq_ack_in), .last_vec_out(last_vec),
    .taken_out(taken));

  always #25 clk_sys_in = ~clk_sys_in;

  // Pulse and wake counters; tests compare deltas, never absolute values
  always @(posedge clk_sys_in) begin
    if (pin_change_group_lo_req === 1'b1) lo_pulses <= lo_pulses + 1;
    if (pin_change_group_hi_req === 1'b1) hi_pulses <= hi_pulses + 1;
    if (wake_out === 1'b1) wake_cyc <= wake_cyc + 1;
  end

  // ======
  // Tasks
  task close_out;
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk_val(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task chk_bit(input logic got, input logic exp);
    chk_val({31'h0, got}, {31'h0, exp});
  endtask

  task tmo;
    error_cnt++;
    $display("[ERR] t=%0t got=%h exp=%h wait ran out", $time, 1'b0, 1'b1);
    close_out;
  endtask

  // Entered just after a rising edge; ends one edge after release
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) tmo;
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys_in);
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk_val(rd, exp);
  endtask

  task wait_taken(input int n);
    int k;
    k = 0;
    while (taken < n && k < 400) begin
      @(posedge clk_sys_in);
      k++;
    end
    if (taken < n) tmo;
  endtask

  // Signal select: 0 request, 1 wake, 2 I/O clock enable
  task wait_lvl(input int s, input logic v);
    int   k;
    logic x;
    k = 0;
    x = ~v;
    while (x !== v && k < 400) begin
      @(posedge clk_sys_in);
      k++;
      x = (s == 0) ? irq_req_out : (s == 1) ? wake_out : io_clk_en_out;
    end
    if (x !== v) tmo;
  endtask

  // ======
  // Tests
  initial begin
    repeat (4) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    @(posedge clk_sys_in);
    for (int i = 0; i < 7; i++) rdc(12'(i * 4), rst_tab[i]);
    apb(1'b0, 12'h01c, 32'h0);
    chk_bit(err, 1'b1);
    chk_val(rd, 32'h0);
    apb(1'b1, 12'h020, 32'hffffffff);
    chk_bit(err, 1'b1);
    wr(irq_pkg::ADDR_PINS, 32'h0);
    rdc(irq_pkg::ADDR_PINS, 32'h1000);
    $display("test registers done");

    // A slow core answer here exercises a request that must stand
    global_irq_en_in <= 1'b1;
    ack_dly <= 4'h5;
    for (int i = 0; i < 13; i++) begin
      t0 = taken;
      periph_req_in <= 14'h1 << i;
      wait_taken(t0 + 1);
      chk_val({27'h0, last_vec}, {27'h0, irq_pkg::VEC_WDOG + 5'(i)});
      periph_req_in <= 14'h0;
      wait_lvl(0, 1'b0);
      repeat (4) @(posedge clk_sys_in);
    end
    ack_dly <= 4'h0;
    periph_req_in <= 14'h1;
    reset_req_in <= 1'b1;
    repeat (3) @(posedge clk_sys_in);
    chk_bit(irq_req_out, 1'b0);
    chk_val({27'h0, irq_vector_out}, {27'h0, irq_pkg::VEC_RESET});
    reset_req_in <= 1'b0;
    periph_req_in <= 14'h0;
    repeat (4) @(posedge clk_sys_in);
    $display("test vectors done");

    wr(irq_pkg::ADDR_ENABLE, 32'h6);
    wr(irq_pkg::ADDR_MASK_LO, 32'h1);
    wr(irq_pkg::ADDR_MASK_HI, 32'h2);
    t0 = taken;
    p0 = lo_pulses;
    pin_change_inputs <= pin_change_inputs ^ 12'h102;
    repeat (12) @(posedge clk_sys_in);
    chk_val(taken - t0, 32'h0);
    rdc(irq_pkg::ADDR_FLAGS, 32'h0);
    pin_change_inputs <= pin_change_inputs ^ 12'h001;
    wait_taken(t0 + 1);
    chk_val({27'h0, last_vec}, {27'h0, irq_pkg::VEC_PC_LO});
    chk_val(lo_pulses - p0, 32'h1);
    p0 = hi_pulses;
    pin_change_inputs <= pin_change_inputs ^ 12'h200;
    wait_taken(t0 + 2);
    chk_val({27'h0, last_vec}, {27'h0, irq_pkg::VEC_PC_HI});
    chk_val(hi_pulses - p0, 32'h1);
    rdc(irq_pkg::ADDR_FLAGS, 32'h0);
    auto_en <= 1'b0;
    pin_change_inputs <= pin_change_inputs ^ 12'h001;
    repeat (12) @(posedge clk_sys_in);
    rdc(irq_pkg::ADDR_FLAGS, 32'h2);
    wr(irq_pkg::ADDR_FLAGS, 32'h2);
    rdc(irq_pkg::ADDR_FLAGS, 32'h0);
    wait_lvl(0, 1'b0);
    auto_en <= 1'b1;
    $display("test pin change done");

    wr(irq_pkg::ADDR_ENABLE, 32'h1);
    for (int m = 0; m < 3; m++) begin
      wr(irq_pkg::ADDR_CTRL, {30'h0, sense_tab[m]});
      t0 = taken;
      ext_irq_pin <= 1'b0;
      repeat (12) @(posedge clk_sys_in);
      chk_val(taken - t0, fall_tab[m]);
      t0 = taken;
      ext_irq_pin <= 1'b1;
      repeat (12) @(posedge clk_sys_in);
      chk_val(taken - t0, rise_tab[m]);
    end
    chk_val({27'h0, last_vec}, {27'h0, irq_pkg::VEC_EXT});
    auto_en <= 1'b0;
    wr(irq_pkg::ADDR_CTRL, 32'h0);
    repeat (6) @(posedge clk_sys_in);
    chk_bit(irq_req_out, 1'b0);
    ext_irq_pin <= 1'b0;
    wait_lvl(0, 1'b1);
    repeat (20) @(posedge clk_sys_in);
    chk_bit(irq_req_out, 1'b1);
    rdc(irq_pkg::ADDR_FLAGS, 32'h0);
    ext_irq_pin <= 1'b1;
    wait_lvl(0, 1'b0);
    $display("test sense done");

    wr(irq_pkg::ADDR_CTRL, {30'h0, irq_pkg::SENSE_FALL});
    wr(irq_pkg::ADDR_ENABLE, 32'h3);
    t0 = taken;
    ext_irq_pin <= 1'b0;
    pin_change_inputs <= pin_change_inputs ^ 12'h001;
    wait_lvl(0, 1'b1);
    repeat (3) @(posedge clk_sys_in);
    chk_val({27'h0, irq_vector_out}, {27'h0, irq_pkg::VEC_EXT});
    auto_en <= 1'b1;
    wait_taken(t0 + 2);
    chk_val({27'h0, last_vec}, {27'h0, irq_pkg::VEC_PC_LO});
    $display("test priority done");

    ext_irq_pin <= 1'b1;
    wr(irq_pkg::ADDR_STARTUP, 32'h8);
    rdc(irq_pkg::ADDR_STARTUP, 32'h8);
    sleep_idle_in <= 1'b1;
    sleep_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    chk_bit(io_clk_en_out, 1'b1);
    sleep_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    sleep_idle_in <= 1'b0;
    sleep_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    chk_bit(io_clk_en_out, 1'b0);
    t0 = taken;
    ext_irq_pin <= 1'b0;
    repeat (12) @(posedge clk_sys_in);
    chk_bit(wake_out, 1'b0);
    p0 = wake_cyc;
    pin_change_inputs <= pin_change_inputs ^ 12'h001;
    wait_lvl(1, 1'b1);
    sleep_in <= 1'b0;
    wait_lvl(2, 1'b1);
    // Start-up is base 8 plus fuse byte 1; edge sampling allows a little slack
    chk_bit(wake_cyc - p0 >= 9 && wake_cyc - p0 <= 12, 1'b1);
    wait_taken(t0 + 1);
    chk_val({27'h0, last_vec}, {27'h0, irq_pkg::VEC_PC_LO});
    rdc(irq_pkg::ADDR_FLAGS, 32'h0);
    ext_irq_pin <= 1'b1;
    repeat (6) @(posedge clk_sys_in);
    wr(irq_pkg::ADDR_CTRL, 32'h0);
    wr(irq_pkg::ADDR_ENABLE, 32'h1);
    t0 = taken;
    sleep_in <= 1'b1;
    repeat (4) @(posedge clk_sys_in);
    ext_irq_pin <= 1'b0;
    wait_lvl(1, 1'b1);
    ext_irq_pin <= 1'b1;
    sleep_in <= 1'b0;
    wait_lvl(2, 1'b1);
    repeat (10) @(posedge clk_sys_in);
    chk_val(taken - t0, 32'h0);
    $display("test sleep done");
    close_out;
  end

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    tmo;
  end
endmodule
